// ===== hw/scu_stack_unit.sv
// stack control unit: data push/pop and linkage save/restore
`timescale 1ns/1ps
`include "scu_regs.svh"
module scu_stack_unit (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               cmdValid,
  output logic                    cmdReady,
  input  wire scu_pkg::scu_cmd_s  cmd,
  output logic                    memReq,
  output scu_pkg::scu_mem_s       mem,
  input  wire logic               memAck,
  input  wire logic [15:0]        memRdata,
  input  wire logic               hostRegWe,
  input  wire logic [2:0]         hostRegIdx,
  input  wire logic [15:0]        hostRegWdata,
  output logic      [15:0]        hostRegRdata,
  input  wire logic               pswStackExcClr,
  output logic                    pswStackExc,
  output logic                    stackTrap,
  output logic                    opDone,
  output logic                    iarLoad,
  output logic      [15:0]        nextInstPtr
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_END, ST_RD_FLR, ST_RD_TOP, ST_RD_CW, ST_CHECK,
    ST_RD_REG, ST_WR_ISSUE, ST_MEM_WR, ST_MEM_RD, ST_WR_CW,
    ST_LIM_WR, ST_WR_TOP
  } scu_state_e;

  scu_state_e        stateQ;
  scu_state_e        stateD;
  scu_pkg::scu_cmd_s cmdQ;
  scu_pkg::scu_mem_s issueMem;
  logic              issue;
  logic [15:0]       endQ;
  logic [15:0]       floorQ;
  logic [15:0]       topQ;
  logic [15:0]       cwQ;
  logic [15:0]       ptrQ;
  logic [15:0]       nextTopQ;
  logic [15:0]       linkQ;
  logic [3:0]        kQ;
  logic [3:0]        itemsQ;
  logic              isPush;
  logic              isPop;
  logic              isLink;
  logic              grows;
  logic              fault;
  logic              lastItem;
  logic [15:0]       elemLen;
  logic [2:0]        limSel;
  logic [7:0]        cntSel;
  logic [3:0]        nSaved;
  logic [16:0]       blkBytes;
  logic [16:0]       lenSel;
  logic [16:0]       downTop;
  logic [16:0]       upTop;
  logic [15:0]       baseAddr;
  logic [15:0]       firstPtr;
  logic [15:0]       cwOut;
  logic [2:0]        curIdx;
  logic              rfWe;
  logic [2:0]        rfWidx;
  logic [15:0]       rfWdata;
  logic [2:0]        rfRidx;
  logic [15:0]       rfRdata;

  // operation class decode
  assign isPush = cmdQ.op inside {scu_pkg::SCU_PUSH_B, scu_pkg::SCU_PUSH_W, scu_pkg::SCU_PUSH_D};
  assign isPop  = cmdQ.op inside {scu_pkg::SCU_POP_B, scu_pkg::SCU_POP_W, scu_pkg::SCU_POP_D};
  assign isLink = (cmdQ.op == scu_pkg::SCU_SAVE) || (cmdQ.op == scu_pkg::SCU_RESTORE);
  assign grows  = isPush || (cmdQ.op == scu_pkg::SCU_SAVE);

  // element length for data stacking
  always_comb begin
    case (cmdQ.op)
      scu_pkg::SCU_PUSH_B, scu_pkg::SCU_POP_B: elemLen = `SCU_LEN_B;
      scu_pkg::SCU_PUSH_D, scu_pkg::SCU_POP_D: elemLen = `SCU_LEN_D;
      default:                                 elemLen = `SCU_LEN_W;
    endcase
  end

  // restore takes limit and count from the stacked control word
  assign limSel = (cmdQ.op == scu_pkg::SCU_RESTORE) ?
                  cwQ[`SCU_CW_LIM_MSB:`SCU_CW_LIM_LSB] : cmdQ.limitIdx;
  assign cntSel = (cmdQ.op == scu_pkg::SCU_RESTORE) ?
                  cwQ[`SCU_CW_CNT_MSB:0] : cmdQ.count;

  // a limit of the link register saves the link register alone
  assign nSaved   = (limSel == `SCU_LINK_REG) ? 4'h1 : {1'b0, limSel} + 4'h2;
  // block words = count + saved + control word, bytes twice that
  assign blkBytes = {7'h00, {1'b0, cntSel} + {5'h00, nSaved} + 9'h001, 1'b0};
  assign lenSel   = isLink ? blkBytes : {1'b0, elemLen};
  // 17 bits so a pointer wrapping below zero counts as overflow
  assign downTop  = {1'b0, topQ} - lenSel;
  assign upTop    = {1'b0, topQ} + lenSel;

  // overflow below floor, underflow at or past end bound
  always_comb begin
    if (grows) begin
      fault = downTop[16] || (downTop[15:0] < floorQ);
    end else if (isLink) begin
      fault = (topQ >= endQ) || (upTop > {1'b0, endQ});
    end else begin
      fault = (topQ >= endQ);
    end
  end

  // layout upward from new top: control word, work area, link, R0..limit
  assign baseAddr = grows ? downTop[15:0] : topQ;
  assign firstPtr = isLink ? baseAddr + {7'h00, cntSel, 1'b0} + `SCU_WORD : baseAddr;
  assign lastItem = (kQ + 4'h1 == itemsQ);

  // control entry: limit index in the top bits, count in the low byte
  always_comb begin
    cwOut = '0;
    cwOut[`SCU_CW_LIM_MSB:`SCU_CW_LIM_LSB] = limSel;
    cwOut[`SCU_CW_CNT_MSB:0] = cntSel;
  end

  // link register first, then R0 upward; doublewords use a pair
  always_comb begin
    if (isLink) begin
      curIdx = (kQ == 4'h0) ? `SCU_LINK_REG : 3'(kQ - 4'h1);
    end else begin
      curIdx = cmdQ.regIdx + kQ[2:0];
    end
  end

  // sequencing and memory request generation
  always_comb begin
    stateD   = stateQ;
    issue    = 1'b0;
    issueMem = '0;
    case (stateQ)
      ST_IDLE: begin
        if (cmdValid) begin
          stateD        = ST_RD_END;
          issue         = 1'b1;
          issueMem.addr = cmd.cbAddr + `SCU_CB_END;
        end
      end
      ST_RD_END: begin
        if (memAck) begin
          stateD        = ST_RD_FLR;
          issue         = 1'b1;
          issueMem.addr = cmdQ.cbAddr + `SCU_CB_FLOOR;
        end
      end
      ST_RD_FLR: begin
        if (memAck) begin
          stateD        = ST_RD_TOP;
          issue         = 1'b1;
          issueMem.addr = cmdQ.cbAddr + `SCU_CB_TOP;
        end
      end
      ST_RD_TOP: begin
        if (memAck) begin
          // an empty stack has no control word worth reading
          if ((cmdQ.op == scu_pkg::SCU_RESTORE) && (memRdata < endQ)) begin
            stateD        = ST_RD_CW;
            issue         = 1'b1;
            issueMem.addr = memRdata;
          end else begin
            stateD = ST_CHECK;
          end
        end
      end
      ST_RD_CW: begin
        if (memAck) begin
          stateD = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (fault) begin
          stateD = ST_IDLE;
        end else if (grows) begin
          stateD = ST_RD_REG;
        end else begin
          stateD           = ST_MEM_RD;
          issue            = 1'b1;
          issueMem.addr    = firstPtr;
          issueMem.byteAcc = (cmdQ.op == scu_pkg::SCU_POP_B);
        end
      end
      ST_RD_REG: begin
        stateD = ST_WR_ISSUE;
      end
      ST_WR_ISSUE: begin
        stateD           = ST_MEM_WR;
        issue            = 1'b1;
        issueMem.addr    = ptrQ;
        issueMem.we      = 1'b1;
        issueMem.byteAcc = (cmdQ.op == scu_pkg::SCU_PUSH_B);
        issueMem.wdata   = issueMem.byteAcc ? {8'h00, rfRdata[7:0]} : rfRdata;
      end
      ST_MEM_WR: begin
        if (memAck) begin
          if (!lastItem) begin
            stateD = ST_RD_REG;
          end else if (isLink) begin
            stateD         = ST_WR_CW;
            issue          = 1'b1;
            issueMem.addr  = nextTopQ;
            issueMem.we    = 1'b1;
            issueMem.wdata = cwOut;
          end else begin
            stateD         = ST_WR_TOP;
            issue          = 1'b1;
            issueMem.addr  = cmdQ.cbAddr + `SCU_CB_TOP;
            issueMem.we    = 1'b1;
            issueMem.wdata = nextTopQ;
          end
        end
      end
      ST_MEM_RD: begin
        if (memAck) begin
          issue = 1'b1;
          if (lastItem) begin
            stateD         = ST_WR_TOP;
            issueMem.addr  = cmdQ.cbAddr + `SCU_CB_TOP;
            issueMem.we    = 1'b1;
            issueMem.wdata = nextTopQ;
          end else begin
            issueMem.addr = ptrQ + `SCU_WORD;
          end
        end
      end
      ST_WR_CW: begin
        if (memAck) begin
          stateD = ST_LIM_WR;
        end
      end
      ST_LIM_WR: begin
        stateD         = ST_WR_TOP;
        issue          = 1'b1;
        issueMem.addr  = cmdQ.cbAddr + `SCU_CB_TOP;
        issueMem.we    = 1'b1;
        issueMem.wdata = nextTopQ;
      end
      ST_WR_TOP: begin
        if (memAck) begin
          stateD = ST_IDLE;
        end
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= ST_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // memory port: request holds until acknowledged
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      memReq <= 1'b0;
      mem    <= '0;
    end else if (issue) begin
      memReq <= 1'b1;
      mem    <= issueMem;
    end else if (memAck) begin
      memReq <= 1'b0;
    end
  end

  // control block words and the command are captured as they arrive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmdQ   <= '0;
      endQ   <= '0;
      floorQ <= '0;
      topQ   <= '0;
      cwQ    <= '0;
    end else begin
      if (stateQ == ST_IDLE && cmdValid) begin
        cmdQ <= cmd;
      end
      if (memAck) begin
        case (stateQ)
          ST_RD_END: endQ   <= memRdata;
          ST_RD_FLR: floorQ <= memRdata;
          ST_RD_TOP: topQ   <= memRdata;
          ST_RD_CW:  cwQ    <= memRdata;
          default:   cwQ    <= cwQ;
        endcase
      end
    end
  end

  // transfer pointer and item counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptrQ     <= '0;
      nextTopQ <= '0;
      itemsQ   <= '0;
      kQ       <= '0;
    end else if (stateQ == ST_CHECK) begin
      ptrQ     <= firstPtr;
      nextTopQ <= grows ? downTop[15:0] : upTop[15:0];
      itemsQ   <= isLink ? nSaved : ((elemLen == `SCU_LEN_D) ? 4'h2 : 4'h1);
      kQ       <= '0;
    end else if (memAck && (stateQ == ST_MEM_WR || stateQ == ST_MEM_RD)) begin
      ptrQ <= ptrQ + `SCU_WORD;
      kQ   <= kQ + 4'h1;
    end
  end

  // register file writes: popped data, work pointer, or host when idle
  always_comb begin
    rfWe    = 1'b0;
    rfWidx  = hostRegIdx;
    rfWdata = hostRegWdata;
    if (stateQ == ST_MEM_RD) begin
      rfWe    = memAck;
      rfWidx  = curIdx;
      rfWdata = (cmdQ.op == scu_pkg::SCU_POP_B) ? {8'h00, memRdata[7:0]} : memRdata;
    end else if (stateQ == ST_LIM_WR) begin
      rfWe    = 1'b1;
      rfWidx  = limSel;
      rfWdata = nextTopQ + `SCU_WORD;
    end else if (stateQ == ST_IDLE) begin
      rfWe = hostRegWe;
    end
  end
  // host reads are only meaningful while idle
  assign rfRidx       = (stateQ == ST_IDLE) ? hostRegIdx : curIdx;
  assign hostRegRdata = rfRdata;
  assign cmdReady     = (stateQ == ST_IDLE);

  scu_regfile #(
    .DW (16),
    .NR (8)
  ) u_regs (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .we      (rfWe),
    .wIdx    (rfWidx),
    .wData   (rfWdata),
    .rIdx    (rfRidx),
    .rData   (rfRdata)
  );

  // saved link value is held apart so the branch sees it last
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      linkQ <= '0;
    end else if (stateQ == ST_MEM_RD && memAck && isLink && kQ == 4'h0) begin
      linkQ <= memRdata;
    end
  end

  // completion, trap and branch pulses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stackTrap   <= 1'b0;
      opDone      <= 1'b0;
      iarLoad     <= 1'b0;
      nextInstPtr <= '0;
    end else begin
      stackTrap <= (stateQ == ST_CHECK) && fault;
      opDone    <= (stateQ == ST_WR_TOP) && memAck;
      iarLoad   <= (stateQ == ST_WR_TOP) && memAck && (cmdQ.op == scu_pkg::SCU_RESTORE);
      if ((stateQ == ST_WR_TOP) && memAck && (cmdQ.op == scu_pkg::SCU_RESTORE)) begin
        nextInstPtr <= linkQ;
      end
    end
  end

  // sticky stack exception status; a new trap beats a clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pswStackExc <= 1'b0;
    end else if (stackTrap) begin
      pswStackExc <= 1'b1;
    end else if (pswStackExcClr) begin
      pswStackExc <= 1'b0;
    end
  end

  // checks on the unit's own behaviour
  trapPsw_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stackTrap |=> pswStackExc)
    else $error("trap did not set stack exception");
  pushOvf_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == ST_CHECK && isPush && (downTop[16] || downTop[15:0] < floorQ)) |=> stackTrap && !memReq)
    else $error("push overflow missed");
  popUnf_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == ST_CHECK && isPop && topQ >= endQ) |=> stackTrap)
    else $error("pop underflow missed");
  trapQuiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stackTrap |-> !memReq && !$past(rfWe))
    else $error("trap modified state");
  pushTop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == ST_WR_TOP && memReq && isPush) |-> mem.wdata == topQ - elemLen && mem.we)
    else $error("push top wrong");
  popTop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == ST_WR_TOP && memReq && isPop) |-> mem.wdata == topQ + elemLen)
    else $error("pop top wrong");
  saveTop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == ST_WR_TOP && memReq && cmdQ.op == scu_pkg::SCU_SAVE) |->
      {1'b0, mem.wdata} == {1'b0, topQ} - blkBytes)
    else $error("save top wrong");
  limPtr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == ST_LIM_WR) |-> rfWdata == nextTopQ + `SCU_WORD && rfWidx == cmdQ.limitIdx)
    else $error("work pointer wrong");
  iarBranch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    iarLoad |-> opDone && nextInstPtr == linkQ)
    else $error("return branch wrong");
  floorRd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == ST_RD_FLR && memReq) |-> mem.addr == cmdQ.cbAddr + `SCU_CB_FLOOR)
    else $error("floor address wrong");

  pushDone_c: cover property (@(posedge clk_sys) disable iff (!rst_n) opDone && isPush);
  popDone_c: cover property (@(posedge clk_sys) disable iff (!rst_n) opDone && isPop);
  saveDone_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    opDone && cmdQ.op == scu_pkg::SCU_SAVE);
  restoreDone_c: cover property (@(posedge clk_sys) disable iff (!rst_n) iarLoad);
  trap_c: cover property (@(posedge clk_sys) disable iff (!rst_n) stackTrap);
endmodule

// ===== hw/scu_regs.svh
// offsets, field positions and lengths of the stack control unit
`ifndef SCU_REGS_SVH
`define SCU_REGS_SVH
`define SCU_CB_END    16'h0000
`define SCU_CB_FLOOR  16'h0002
`define SCU_CB_TOP    16'h0004
`define SCU_LEN_B     16'h0001
`define SCU_LEN_W     16'h0002
`define SCU_LEN_D     16'h0004
`define SCU_WORD      16'h0002
`define SCU_LINK_REG  3'h7
`define SCU_CW_LIM_MSB 15
`define SCU_CW_LIM_LSB 13
`define SCU_CW_CNT_MSB 7
`endif

// ===== hw/scu_pkg.sv
// types shared by the stack control unit
package scu_pkg;
  typedef enum logic [2:0] {
    SCU_PUSH_B, SCU_PUSH_W, SCU_PUSH_D,
    SCU_POP_B, SCU_POP_W, SCU_POP_D,
    SCU_SAVE, SCU_RESTORE
  } scu_op_e;
  typedef struct packed {
    scu_op_e     op;
    logic [15:0] cbAddr;
    logic [2:0]  regIdx;
    logic [2:0]  limitIdx;
    logic [7:0]  count;
  } scu_cmd_s;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        byteAcc;
  } scu_mem_s;
endpackage

// ===== hw/scu_regfile.sv
// general register file, one write port, registered read port
`timescale 1ns/1ps
module scu_regfile #(
  parameter int DW = 16,
  parameter int NR = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  we,
  input  wire logic [$clog2(NR)-1:0] wIdx,
  input  wire logic [DW-1:0]         wData,
  input  wire logic [$clog2(NR)-1:0] rIdx,
  output logic      [DW-1:0]         rData
);
  logic [DW-1:0] memQ [NR];

  // storage, cleared at reset so every read is defined
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NR; i++) begin
        memQ[i] <= '0;
      end
    end else if (we) begin
      memQ[wIdx] <= wData;
    end
  end

  // read data comes one cycle after the address
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rData <= '0;
    end else begin
      rData <= memQ[rIdx];
    end
  end
endmodule

// ===== test/scu_mem_model.sv
// main storage model answering the stack unit's requests
`timescale 1ns/1ps
module scu_mem_model (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              memReq,
  input  wire scu_pkg::scu_mem_s mem,
  input  wire logic [1:0]        lat,
  output logic                   memAck,
  output logic [15:0]            memRdata
);
  logic [7:0]  bytes [0:65535];
  logic [1:0]  waitQ;
  logic [15:0] lastQ;
  logic [15:0] rdVal;

  // words are big-endian; byte accesses use the low data byte
  assign rdVal = mem.byteAcc ? {8'h00, bytes[mem.addr]} : {bytes[mem.addr], bytes[mem.addr | 16'h0001]};
  // outside the ack cycle the bus shows the inverse of the last data, never stale data
  assign memRdata = memAck ? rdVal : ~lastQ;

  // ack after lat waiting cycles, only while a request stands; one cycle each
  // plain always: the bench also preloads the byte array directly
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      memAck <= 1'b0;
      waitQ  <= 2'h0;
      lastQ  <= 16'h0000;
    end else if (memAck) begin
      memAck <= 1'b0;
      waitQ  <= 2'h0;
      lastQ  <= mem.we ? mem.wdata : rdVal;
    end else if (memReq && waitQ >= lat) begin
      memAck <= 1'b1;
      if (mem.we && mem.byteAcc) begin
        bytes[mem.addr] <= mem.wdata[7:0];
      end else if (mem.we) begin
        bytes[mem.addr]             <= mem.wdata[15:8];
        bytes[mem.addr | 16'h0001] <= mem.wdata[7:0];
      end
    end else if (memReq) begin
      waitQ <= waitQ + 2'h1;
    end
  end
endmodule

// ===== test/stack_control_unit_bench.sv
// self-checking bench for the stack control unit
`timescale 1ns/1ps
`include "scu_regs.svh"
module stack_control_unit_bench;
  localparam logic [15:0] CB = 16'h0100;
  logic                clk_sys;
  logic                rst_n;
  logic                cmdValid;
  logic                cmdReady;
  scu_pkg::scu_cmd_s   cmd;
  logic                memReq;
  scu_pkg::scu_mem_s   mem;
  logic                memAck;
  logic [15:0]         memRdata;
  logic [1:0]          lat;
  logic                hostRegWe;
  logic [2:0]          hostRegIdx;
  logic [15:0]         hostRegWdata;
  logic [15:0]         hostRegRdata;
  logic                pswStackExcClr;
  logic                pswStackExc;
  logic                stackTrap;
  logic                opDone;
  logic                iarLoad;
  logic [15:0]         nextInstPtr;
  logic [1:0]          noteQ [$];
  logic [1:0]          exp;
  logic [15:0]         rv [8];
  int                  error_cnt = 0;
  int                  compares = 0;
  int                  resCnt = 0;

  scu_stack_unit scu_stack_unit_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmd(cmd), .memReq(memReq), .mem(mem), .memAck(memAck), .memRdata(memRdata),
    .hostRegWe(hostRegWe), .hostRegIdx(hostRegIdx), .hostRegWdata(hostRegWdata),
    .hostRegRdata(hostRegRdata), .pswStackExcClr(pswStackExcClr), .pswStackExc(pswStackExc),
    .stackTrap(stackTrap), .opDone(opDone), .iarLoad(iarLoad), .nextInstPtr(nextInstPtr));
  scu_mem_model scu_mem_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .memReq(memReq), .mem(mem),
    .lat(lat), .memAck(memAck), .memRdata(memRdata));

  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] rd16(input logic [15:0] a);
    return {scu_mem_model_inst.bytes[a], scu_mem_model_inst.bytes[a + 16'h0001]};
  endfunction

  task automatic wr16(input logic [15:0] a, input logic [15:0] v);
    scu_mem_model_inst.bytes[a] = v[15:8];
    scu_mem_model_inst.bytes[a + 16'h0001] = v[7:0];
  endtask

  // control blocks sit on a word boundary and word stacks keep even bounds
  task automatic setcb(input logic [15:0] e, input logic [15:0] f, input logic [15:0] t);
    wr16(CB + `SCU_CB_END, e);
    wr16(CB + `SCU_CB_FLOOR, f);
    wr16(CB + `SCU_CB_TOP, t);
  endtask

  task automatic setReg(input logic [2:0] i, input logic [15:0] v);
    @(negedge clk_sys);
    hostRegWe = 1'b1;
    hostRegIdx = i;
    hostRegWdata = v;
    @(negedge clk_sys);
    hostRegWe = 1'b0;
  endtask

  task automatic getReg(input logic [2:0] i, output logic [15:0] v);
    @(negedge clk_sys);
    hostRegIdx = i;
    @(negedge clk_sys);
    v = hostRegRdata;
  endtask

  task automatic loadRegs();
    for (int i = 0; i < 8; i++) begin
      rv[i] = 16'($urandom);
      setReg(3'(i), rv[i]);
    end
  endtask

  // issue one command, note {iarLoad, trap} expected, wait for the outcome pulse
  task automatic run(input scu_pkg::scu_op_e o, input logic [2:0] r, input logic [2:0] l,
                     input logic [7:0] c, input logic [1:0] want);
    int r0;
    r0 = resCnt;
    noteQ.push_back(want);
    @(negedge clk_sys);
    cmd = '{op: o, cbAddr: CB, regIdx: r, limitIdx: l, count: c};
    cmdValid = 1'b1;
    // ready is sampled away from the edge so the take edge is never missed
    while (cmdReady !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    cmdValid = 1'b0;
    for (int n = 0; n < 400 && resCnt == r0; n++) @(negedge clk_sys);
    if (resCnt == r0) check("completion", 16'h0000, 16'h0001);
    // one more cycle lets the sticky status follow the trap pulse
    @(negedge clk_sys);
  endtask

  // outcome watcher: every done or trap pulse is matched with the oldest note
  always @(negedge clk_sys) begin
    if (rst_n === 1'b1 && (opDone === 1'b1 || stackTrap === 1'b1)) begin
      exp = noteQ.size() > 0 ? noteQ.pop_front() : 2'b11;
      check("outcome", {14'h0000, iarLoad, stackTrap}, {14'h0000, exp});
      resCnt++;
    end
  end

  // latency of storage varies every cycle
  always @(negedge clk_sys) lat <= 2'($urandom_range(3, 0));

  // watchdog well above the expected run length
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    scu_pkg::scu_op_e pu [3] = '{scu_pkg::SCU_PUSH_W, scu_pkg::SCU_PUSH_D, scu_pkg::SCU_PUSH_B};
    scu_pkg::scu_op_e po [3] = '{scu_pkg::SCU_POP_W, scu_pkg::SCU_POP_D, scu_pkg::SCU_POP_B};
    scu_pkg::scu_op_e fo [6] = '{scu_pkg::SCU_POP_W, scu_pkg::SCU_POP_B, scu_pkg::SCU_PUSH_D,
                                 scu_pkg::SCU_SAVE, scu_pkg::SCU_RESTORE, scu_pkg::SCU_RESTORE};
    logic [15:0] ft [6] = '{16'h0300, 16'h0302, 16'h0300, 16'h0300, 16'h0300, 16'h02fe};
    logic [15:0] ff [6] = '{16'h0200, 16'h0200, 16'h02fe, 16'h02f0, 16'h0200, 16'h0200};
    logic [15:0] ln [3] = '{16'h0002, 16'h0004, 16'h0001};
    logic [2:0]  rg [3] = '{3'h1, 3'h3, 3'h2};
    logic [2:0]  pr [3] = '{3'h0, 3'h5, 3'h7};
    logic [15:0] v, t, nt, a, ip;
    logic [2:0]  lim;
    logic [7:0]  cnt;
    int          ns;
    void'($urandom(32'hbf9a540b));
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmd = '0;
    hostRegWe = 1'b0;
    hostRegIdx = 3'h0;
    hostRegWdata = 16'h0000;
    pswStackExcClr = 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;

    // word, doubleword and byte pushed onto an empty stack, popped back in reverse
    setcb(16'h0300, 16'h0200, 16'h0300);
    loadRegs();
    t = 16'h0300;
    for (int k = 0; k < 3; k++) begin
      t = t - ln[k];
      run(pu[k], rg[k], 3'h0, 8'h00, 2'b00);
      check("push top", rd16(CB + `SCU_CB_TOP), t);
      v = ln[k] == 16'h0001 ? {8'h00, scu_mem_model_inst.bytes[t]} : rd16(t);
      check("pushed", v, ln[k] == 16'h0001 ? {8'h00, rv[2][7:0]} : rv[rg[k]]);
    end
    check("dw second", rd16(16'h02fc), rv[4]);
    for (int k = 2; k >= 0; k--) begin
      run(po[k], pr[k], 3'h0, 8'h00, 2'b00);
      t = t + ln[k];
      check("pop top", rd16(CB + `SCU_CB_TOP), t);
      getReg(pr[k], v);
      check("popped", v, ln[k] == 16'h0001 ? {8'h00, rv[2][7:0]} : rv[rg[k]]);
    end
    getReg(3'h6, v);
    check("dw pop hi", v, rv[4]);
    $display("test push_pop done");

    // save then restore, with a work area and with the link register as limit
    for (int c = 0; c < 2; c++) begin
      lim = c == 1 ? 3'h7 : 3'h4;
      cnt = c == 1 ? 8'h00 : 8'h0a;
      ns = lim == 3'h7 ? 1 : int'(lim) + 2;
      nt = 16'h0300 - 16'(2 * (int'(cnt) + ns + 1));
      a = nt + 16'h0002 + {7'h00, cnt, 1'b0};
      setcb(16'h0300, 16'h0200, 16'h0300);
      loadRegs();
      run(scu_pkg::SCU_SAVE, 3'h0, lim, cnt, 2'b00);
      check("save top", rd16(CB + `SCU_CB_TOP), nt);
      check("ctrl word", rd16(nt), {lim, 5'h00, cnt});
      check("link saved", rd16(a), rv[7]);
      for (int i = 0; i <= int'(lim) && lim != 3'h7; i++) check("reg saved", rd16(a + 16'(2 + 2 * i)), rv[i]);
      getReg(lim, v);
      check("work ptr", v, nt + 16'h0002);
      for (int i = 0; i < 8; i++) setReg(3'(i), ~rv[i]);
      run(scu_pkg::SCU_RESTORE, 3'h0, 3'h0, 8'h00, 2'b10);
      check("restore top", rd16(CB + `SCU_CB_TOP), 16'h0300);
      check("return ptr", nextInstPtr, rv[7]);
      for (int i = 0; i < 8; i++) begin
        getReg(3'(i), v);
        check("reg restored", v, (i == 7 || (lim != 3'h7 && i <= int'(lim))) ? rv[i] : ~rv[i]);
      end
    end
    $display("test save_restore done");

    // overflow and underflow of every kind: trap, nothing changes
    for (int k = 0; k < 6; k++) begin
      setcb(16'h0300, ff[k], ft[k]);
      wr16(16'h02fe, 16'h800a);
      loadRegs();
      ip = nextInstPtr;
      run(fo[k], 3'h1, 3'h4, 8'h0a, 2'b01);
      check("fault top", rd16(CB + `SCU_CB_TOP), ft[k]);
      check("exc bit", {15'h0000, pswStackExc}, 16'h0001);
      check("iar kept", nextInstPtr, ip);
      getReg(3'h1, v);
      check("target kept", v, rv[1]);
      getReg(3'h4, v);
      check("limit kept", v, rv[4]);
      @(negedge clk_sys);
      pswStackExcClr = 1'b1;
      @(negedge clk_sys);
      pswStackExcClr = 1'b0;
      check("exc clear", {15'h0000, pswStackExc}, 16'h0000);
    end
    // a push landing exactly on the floor is allowed
    setcb(16'h0300, 16'h02fe, 16'h0300);
    run(scu_pkg::SCU_PUSH_W, 3'h1, 3'h0, 8'h00, 2'b00);
    check("floor push", rd16(CB + `SCU_CB_TOP), 16'h02fe);
    $display("test faults done");
    give_verdict();
  end
endmodule
